// ### duart_status_pkg.sv
// Constants and carrier types for the channel status and output port block.
package duart_status_pkg;

    // ========================================================================
    // Sizes
    localparam int CHANNELS = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W = 3;
    localparam logic [3:0] FIFO_FULL_CNT = 4'h8;

    // ========================================================================
    // Register indices; the byte address is four times the index.
    localparam logic [1:0][5:0] IDX_STATUS = {6'h09, 6'h01};
    localparam logic [1:0][5:0] IDX_CMD = {6'h0A, 6'h02};
    localparam logic [1:0][5:0] IDX_RXDATA = {6'h0B, 6'h03};
    localparam logic [5:0] IDX_OUTPUT_PIN_FUNCTION_CONFIG = 6'h0D;
    localparam logic [5:0] IDX_OPR_SET = 6'h0E;
    localparam logic [5:0] IDX_OPR_CLR = 6'h0F;
    localparam logic [5:0] IDX_ERRMODE = 6'h10;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h11;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h12;

    // ========================================================================
    // Status byte fields.
    localparam int ST_BREAK = 7;
    localparam int ST_ERR_LSB = 5;
    localparam int ST_OVERRUN = 4;
    localparam int ST_TX_EMPTY = 3;
    localparam int ST_TX_READY = 2;
    localparam int ST_FIFO_FULL = 1;
    localparam int ST_RX_READY = 0;

    // ========================================================================
    // Output configuration fields and codes.
    localparam int OUTPUT_PIN_FUNCTION_CONFIG_OP7 = 7;
    localparam int OUTPUT_PIN_FUNCTION_CONFIG_OP6 = 6;
    localparam int OUTPUT_PIN_FUNCTION_CONFIG_OP5 = 5;
    localparam int OUTPUT_PIN_FUNCTION_CONFIG_OP4 = 4;
    localparam int OUTPUT_PIN_FUNCTION_CONFIG_OP3_LSB = 2;
    localparam logic [1:0] OP3_SEL_OPR = 2'h0;
    localparam logic [1:0] OP3_SEL_CT = 2'h1;

    // ========================================================================
    // Command field, error mode bits, interrupt bits, reset values.
    localparam int CMD_LSB = 4;
    localparam logic [3:0] CMD_RESET_RX = 4'h2;
    localparam logic [3:0] CMD_RESET_ERR = 4'h4;
    localparam int EM_BLOCK_LSB = 0;
    localparam int EM_FULL_LSB = 2;
    localparam int IRQ_RX_LSB = 0;
    localparam int IRQ_ERR_LSB = 2;
    localparam logic [7:0] OUTPUT_PIN_FUNCTION_CONFIG_RESET = 8'h00;
    localparam logic [7:0] OPR_RESET = 8'h00;
    localparam logic [3:0] ERRMODE_RESET = 4'h0;
    localparam logic [3:0] IRQ_RESET = 4'h0;

    // ========================================================================
    // Carrier types.
    typedef struct packed {
        logic       brk;
        logic       framing;
        logic       parity;
        logic [7:0] data;
    } rx_entry_t;

    typedef struct packed {
        logic      push;
        rx_entry_t entry;
        logic      tx_empty;
        logic      tx_ready;
    } chan_in_t;

    // ========================================================================
    // Word-aligned register hit.
    function automatic logic reg_hit(input logic [7:0] addr,
                                     input logic [5:0] idx);
        return (addr[1:0] == 2'h0) && (addr[7:2] == idx);
    endfunction : reg_hit

endpackage : duart_status_pkg

// ### rx_char_fifo.sv
// Eight-entry receive FIFO holding each character with its error flags.
`timescale 1ns/1ns
module rx_char_fifo
    import duart_status_pkg::*;
(
    // Clock and reset.
    input  logic      pclk,
    input  logic      presetn,
    // Control.
    input  logic      push,
    input  rx_entry_t push_entry,
    input  logic      pop,
    input  logic      flush,
    input  logic      clear_flags,
    // State.
    output rx_entry_t head,
    output logic      empty,
    output logic      full,
    output logic      overflow
);

    // ========================================================================
    // Storage and pointers.
    rx_entry_t        mem_reg [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [3:0]       count_reg;
    logic             do_push;
    logic             do_pop;

    assign empty = (count_reg == 4'h0);
    assign full = (count_reg == FIFO_FULL_CNT);
    assign do_pop = pop & ~empty;
    assign do_push = push & (~full | do_pop);
    assign overflow = push & ~do_push;
    assign head = mem_reg[rd_ptr_reg];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_reg <= 3'h0;
            rd_ptr_reg <= 3'h0;
            count_reg <= 4'h0;
        end
        else if (flush)
        begin
            wr_ptr_reg <= 3'h0;
            rd_ptr_reg <= 3'h0;
            count_reg <= 4'h0;
        end
        else
        begin
            if (do_push)
                wr_ptr_reg <= wr_ptr_reg + 3'h1;
            if (do_pop)
                rd_ptr_reg <= rd_ptr_reg + 3'h1;
            if (do_push && !do_pop)
                count_reg <= count_reg + 4'h1;
            else if (do_pop && !do_push)
                count_reg <= count_reg - 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < FIFO_DEPTH; i++)
                mem_reg[i] <= '0;
        end
        else
        begin
            if (clear_flags)
            begin
                for (int i = 0; i < FIFO_DEPTH; i++)
                begin
                    mem_reg[i].brk <= 1'b0;
                    mem_reg[i].framing <= 1'b0;
                    mem_reg[i].parity <= 1'b0;
                end
            end
            if (do_push && !flush)
                mem_reg[wr_ptr_reg] <= push_entry;
        end
    end

endmodule : rx_char_fifo

// ### out_port_mux.sv
// Selects the source of each output port pin.
`timescale 1ns/1ns
module out_port_mux
    import duart_status_pkg::*;
(
    // Configuration and register.
    input  logic [7:0] output_pin_function_config,
    input  logic [7:0] output_port_register,
    // Function sources.
    input  logic       transmitter_ready_chan_a,
    input  logic       transmitter_ready_chan_b,
    input  logic       receive_ready_or_full_chan_a,
    input  logic       receive_ready_or_full_chan_b,
    input  logic       ct_output,
    // Pin levels.
    output logic [7:0] pin_level
);

    // ========================================================================
    // Each pin shows the inverse of its selected source.
    logic [7:0] src;

    always_comb
    begin
        src = output_port_register;
        if (output_pin_function_config[OUTPUT_PIN_FUNCTION_CONFIG_OP7])
            src[7] = transmitter_ready_chan_b;
        if (output_pin_function_config[OUTPUT_PIN_FUNCTION_CONFIG_OP6])
            src[6] = transmitter_ready_chan_a;
        if (output_pin_function_config[OUTPUT_PIN_FUNCTION_CONFIG_OP5])
            src[5] = receive_ready_or_full_chan_b;
        if (output_pin_function_config[OUTPUT_PIN_FUNCTION_CONFIG_OP4])
            src[4] = receive_ready_or_full_chan_a;
        if (output_pin_function_config[OUTPUT_PIN_FUNCTION_CONFIG_OP3_LSB+1:OUTPUT_PIN_FUNCTION_CONFIG_OP3_LSB] == OP3_SEL_CT)
            src[3] = ct_output;
        pin_level = ~src;
    end

endmodule : out_port_mux

// ### duart_status_outport.sv
// Channel status registers, error flags and output port configuration.
`timescale 1ns/1ns
module duart_status_outport
    import duart_status_pkg::*;
(
    // Clock and reset.
    input  logic        pclk,
    input  logic        presetn,

    // APB slave.
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [7:0]  paddr,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,

    // Channel engines.
    input  chan_in_t    chan_a,
    input  chan_in_t    chan_b,
    input  logic        ct_output,

    // Pins and interrupt.
    output logic [7:0]  out_pins,
    output logic        irq
);

    // ========================================================================
    // Bus phase decode.
    logic       setup;
    logic       access;
    logic       wr_access;
    logic       rd_access;
    logic       mapped;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign pready = 1'b1;
    assign wr_access = access & pwrite;
    assign rd_access = access & ~pwrite;

    always_comb
    begin
        mapped = 1'b0;
        if (reg_hit(paddr, IDX_STATUS[0]) || reg_hit(paddr, IDX_STATUS[1]))
            mapped = 1'b1;
        else if (reg_hit(paddr, IDX_CMD[0]) || reg_hit(paddr, IDX_CMD[1]))
            mapped = 1'b1;
        else if (reg_hit(paddr, IDX_RXDATA[0]))
            mapped = 1'b1;
        else if (reg_hit(paddr, IDX_RXDATA[1]))
            mapped = 1'b1;
        else if (reg_hit(paddr, IDX_OUTPUT_PIN_FUNCTION_CONFIG))
            mapped = 1'b1;
        else if (reg_hit(paddr, IDX_OPR_SET))
            mapped = 1'b1;
        else if (reg_hit(paddr, IDX_OPR_CLR))
            mapped = 1'b1;
        else if (reg_hit(paddr, IDX_ERRMODE))
            mapped = 1'b1;
        else if (reg_hit(paddr, IDX_IRQ_STAT))
            mapped = 1'b1;
        else if (reg_hit(paddr, IDX_IRQ_MASK))
            mapped = 1'b1;
    end

    assign pslverr = access & ~mapped;

    // ========================================================================
    // Software registers.
    logic [7:0] output_pin_function_config_reg;
    logic [7:0] opr_reg;
    logic [3:0] errmode_reg;
    logic [3:0] irq_stat_reg;
    logic [3:0] irq_mask_reg;
    logic [3:0] irq_event;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            output_pin_function_config_reg <= OUTPUT_PIN_FUNCTION_CONFIG_RESET;
        else if (wr_access && reg_hit(paddr, IDX_OUTPUT_PIN_FUNCTION_CONFIG))
            output_pin_function_config_reg <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            opr_reg <= OPR_RESET;
        else if (wr_access && reg_hit(paddr, IDX_OPR_SET))
            opr_reg <= opr_reg | pwdata[7:0];
        else if (wr_access && reg_hit(paddr, IDX_OPR_CLR))
            opr_reg <= opr_reg & ~pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            errmode_reg <= ERRMODE_RESET;
        else if (wr_access && reg_hit(paddr, IDX_ERRMODE))
            errmode_reg <= pwdata[3:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask_reg <= IRQ_RESET;
        else if (wr_access && reg_hit(paddr, IDX_IRQ_MASK))
            irq_mask_reg <= pwdata[3:0];
    end

    // New events win over a write-one clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat_reg <= IRQ_RESET;
        else if (wr_access && reg_hit(paddr, IDX_IRQ_STAT))
            irq_stat_reg <= (irq_stat_reg & ~pwdata[3:0]) | irq_event;
        else
            irq_stat_reg <= irq_stat_reg | irq_event;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |((irq_stat_reg | irq_event) & irq_mask_reg);
    end

    // ========================================================================
    // Per-channel receive status.
    chan_in_t [1:0] chin;
    rx_entry_t      head [2];
    logic [1:0]     fifo_empty;
    logic [1:0]     fifo_full;
    logic [1:0]     overflow;
    logic [1:0]     pop;
    logic [1:0]     reset_err;
    logic [1:0]     reset_rx;
    logic [1:0]     rx_status_pin;
    logic [2:0]     accum_reg [2];
    logic [1:0]     overrun_reg;
    logic [7:0]     status [2];
    logic [31:0]    rxdata [2];

    assign chin[0] = chan_a;
    assign chin[1] = chan_b;

    generate
        for (genvar ch = 0; ch < CHANNELS; ch++)
        begin : g_chan
            logic [2:0] head_flags;
            logic [2:0] push_flags;
            logic       block_mode;
            logic       cmd_hit;

            assign cmd_hit = wr_access && reg_hit(paddr, IDX_CMD[ch]);
            assign reset_err[ch] = cmd_hit &&
                (pwdata[CMD_LSB+3:CMD_LSB] == CMD_RESET_ERR);
            assign reset_rx[ch] = cmd_hit &&
                (pwdata[CMD_LSB+3:CMD_LSB] == CMD_RESET_RX);
            assign pop[ch] = rd_access && reg_hit(paddr, IDX_RXDATA[ch]);
            assign block_mode = errmode_reg[EM_BLOCK_LSB+ch];

            rx_char_fifo u_fifo
            (
                .pclk        (pclk),
                .presetn     (presetn),
                .push        (chin[ch].push),
                .push_entry  (chin[ch].entry),
                .pop         (pop[ch]),
                .flush       (reset_rx[ch]),
                .clear_flags (reset_err[ch]),
                .head        (head[ch]),
                .empty       (fifo_empty[ch]),
                .full        (fifo_full[ch]),
                .overflow    (overflow[ch])
            );

            assign push_flags = {chin[ch].entry.brk,
                                 chin[ch].entry.framing,
                                 chin[ch].entry.parity};
            assign head_flags = fifo_empty[ch] ? 3'h0 :
                {head[ch].brk, head[ch].framing, head[ch].parity};

            // Block mode gathers flags of every pushed character, including one dropped on overflow, except one pushed in a receiver reset cycle.
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    accum_reg[ch] <= 3'h0;
                else if (reset_err[ch] || reset_rx[ch] || !block_mode)
                    accum_reg[ch] <= (block_mode && chin[ch].push &&
                        !reset_rx[ch]) ? push_flags : 3'h0;
                else if (chin[ch].push)
                    accum_reg[ch] <= accum_reg[ch] | push_flags;
            end

            // Overrun stays until an error or receiver reset.
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    overrun_reg[ch] <= 1'b0;
                else if (overflow[ch])
                    overrun_reg[ch] <= 1'b1;
                else if (reset_err[ch] || reset_rx[ch])
                    overrun_reg[ch] <= 1'b0;
            end

            assign status[ch][ST_BREAK:ST_ERR_LSB] = block_mode ?
                (accum_reg[ch] | head_flags) : head_flags;
            assign status[ch][ST_OVERRUN] = overrun_reg[ch];
            assign status[ch][ST_TX_EMPTY] = chin[ch].tx_empty;
            assign status[ch][ST_TX_READY] = chin[ch].tx_ready;
            assign status[ch][ST_FIFO_FULL] = fifo_full[ch];
            assign status[ch][ST_RX_READY] = ~fifo_empty[ch];

            assign rxdata[ch] = fifo_empty[ch] ? 32'h0 :
                {24'h0, head[ch].data};
            assign rx_status_pin[ch] = errmode_reg[EM_FULL_LSB+ch] ?
                fifo_full[ch] : ~fifo_empty[ch];

            assign irq_event[IRQ_RX_LSB+ch] = chin[ch].push & ~overflow[ch];
            assign irq_event[IRQ_ERR_LSB+ch] = overflow[ch] |
                (chin[ch].push & (|push_flags));
        end
    endgenerate

    // ========================================================================
    // Read data, captured in the setup cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (setup && !pwrite)
        begin
            if (reg_hit(paddr, IDX_STATUS[0]))
                prdata <= {24'h0, status[0]};
            else if (reg_hit(paddr, IDX_STATUS[1]))
                prdata <= {24'h0, status[1]};
            else if (reg_hit(paddr, IDX_RXDATA[0]))
                prdata <= rxdata[0];
            else if (reg_hit(paddr, IDX_RXDATA[1]))
                prdata <= rxdata[1];
            else if (reg_hit(paddr, IDX_OUTPUT_PIN_FUNCTION_CONFIG))
                prdata <= {24'h0, output_pin_function_config_reg};
            else if (reg_hit(paddr, IDX_ERRMODE))
                prdata <= {28'h0, errmode_reg};
            else if (reg_hit(paddr, IDX_IRQ_STAT))
                prdata <= {28'h0, irq_stat_reg};
            else if (reg_hit(paddr, IDX_IRQ_MASK))
                prdata <= {28'h0, irq_mask_reg};
            else
                prdata <= 32'h0;
        end
    end

    // ========================================================================
    // Output port pins.
    logic [7:0] pin_level;

    out_port_mux u_mux
    (
        .output_pin_function_config                         (output_pin_function_config_reg),
        .output_port_register         (opr_reg),
        .transmitter_ready_chan_a     (chan_a.tx_ready),
        .transmitter_ready_chan_b     (chan_b.tx_ready),
        .receive_ready_or_full_chan_a (rx_status_pin[0]),
        .receive_ready_or_full_chan_b (rx_status_pin[1]),
        .ct_output                    (ct_output),
        .pin_level                    (pin_level)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_pins <= 8'hFF;
        else
            out_pins <= pin_level;
    end

endmodule : duart_status_outport

// ### host_apb_model.sv
// Host processor model issuing APB transfers.
`timescale 1ns/1ns
module host_apb_model (
    // Clock and answer.
    input  logic        pclk,
    input  logic        pready,
    input  logic [31:0] prdata,
    input  logic        pslverr,
    // Request.
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [7:0]  paddr,
    output logic [31:0] pwdata
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // ========================================================================
    // One transfer: setup, then access until pready is seen at an edge.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 100)
        begin
            n++;
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : host_apb_model

// ### duart_status_outport_properties.sv
// Concurrent checks on the status and output port block.
`timescale 1ns/1ns
module duart_status_outport_properties
    import duart_status_pkg::*;
(
    // Clock and reset.
    input logic        pclk,
    input logic        presetn,
    // APB.
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    // Channels, pins and interrupt.
    input chan_in_t    chan_a,
    input chan_in_t    chan_b,
    input logic        ct_output,
    input logic [7:0]  out_pins,
    input logic        irq
);
    // ========================================================================
    // Mirror of the pin configuration and port bits.
    logic [7:0] pin_cfg_reg;
    logic [7:0] port_bits_reg;
    logic [7:0] sel_pins;
    logic       wr_en;
    logic       mapped;
    assign wr_en = psel && penable && pwrite && pready;
    assign mapped = paddr inside {8'h04, 8'h08, 8'h0C, 8'h24, 8'h28,
        8'h2C, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h48};
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            pin_cfg_reg <= 8'h00;
        else if (wr_en && paddr == 8'h34)
            pin_cfg_reg <= pwdata[7:0];
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            port_bits_reg <= 8'h00;
        else if (wr_en && paddr == 8'h38)
            port_bits_reg <= port_bits_reg | pwdata[7:0];
        else if (wr_en && paddr == 8'h3C)
            port_bits_reg <= port_bits_reg & ~pwdata[7:0];
    assign sel_pins = {pin_cfg_reg[7] ? chan_b.tx_ready : port_bits_reg[7],
        pin_cfg_reg[6] ? chan_a.tx_ready : port_bits_reg[6],
        port_bits_reg[5:4],
        pin_cfg_reg[3:2] == 2'h1 ? ct_output : port_bits_reg[3],
        port_bits_reg[2:0]};

    // ========================================================================
    // Properties.
    default clocking cb_main @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_set_write;
        psel && penable && pwrite && paddr == 8'h38;
    endsequence
    a_pin7_mux: assert property (out_pins[7] == !$past(sel_pins[7]))
        else $error("pin 7 source wrong");
    a_pin6_mux: assert property (out_pins[6] == !$past(sel_pins[6]))
        else $error("pin 6 source wrong");
    a_pin54_bits: assert property (
        $past(pin_cfg_reg[5:4] == 2'h0)
        |-> out_pins[5:4] == ~$past(port_bits_reg[5:4]))
        else $error("pins 5 and 4 wrong");
    a_pin3_select: assert property (
        out_pins[3] == !$past(sel_pins[3]))
        else $error("pin 3 source wrong");
    a_low_pins: assert property (
        out_pins[2:0] == ~$past(sel_pins[2:0]))
        else $error("pins 2 to 0 wrong");
    a_set_ones: assert property (s_set_write |-> ##2
        (out_pins[2:0] & $past(pwdata[2:0], 2)) == 3'h0)
        else $error("set write left pin high");
    a_reset_idle: assert property (
        $rose(presetn) |-> out_pins == 8'hFF && !irq)
        else $error("idle levels wrong after reset");
    a_slverr_map: assert property (psel && penable |-> pslverr == !mapped)
        else $error("error response wrong");
    a_pready_high: assert property (psel && penable |-> pready)
        else $error("no ready in access");
    a_unmapped_zero: assert property (psel && penable && !pwrite && !mapped
        |-> prdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : duart_status_outport_properties

bind duart_status_outport duart_status_outport_properties
    i_duart_status_outport_properties (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_a(chan_a), .chan_b(chan_b), .ct_output(ct_output),
    .out_pins(out_pins), .irq(irq));

// ### tb.sv
// Testbench for the status and output port block.
`timescale 1ns/1ns
`define CHK(n, x, s) \
    begin \
        checks_done++; \
        if ((s) !== (x)) \
        begin \
            mismatches++; \
            $display("CHECK FAILED %s exp %0h got %0h", n, x, s); \
        end \
    end
module tb;
    import duart_status_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    chan_in_t    ch [2];
    logic        ct_output;
    logic [7:0]  out_pins;
    logic        irq;
    int          mismatches;
    int          checks_done;

    duart_status_outport i_duart_status_outport (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_a(ch[0]), .chan_b(ch[1]),
        .ct_output(ct_output), .out_pins(out_pins), .irq(irq));
    host_apb_model i_host_apb_model (.pclk(pclk), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ========================================================================
    // Shared tasks.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        i_host_apb_model.xfer(1'b1, a, {24'h0, d}, q, e);
    endtask : wr

    task automatic rd(input string n, input logic [7:0] a,
                      input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic        e;
        i_host_apb_model.xfer(1'b0, a, 32'h0, q, e);
        `CHK(n, {xe, x}, {e, q})
    endtask : rd

    task automatic push(input int b, input logic [10:0] e);
        @(posedge pclk);
        ch[b].push <= 1'b1;
        ch[b].entry <= e;
        @(posedge pclk);
        ch[b].push <= 1'b0;
        ch[b].entry <= ~e;
    endtask : push

    task automatic settle;
        @(posedge pclk);
        @(negedge pclk);
    endtask : settle

    // ========================================================================
    // Scenarios.
    task automatic t_reset;
        @(negedge pclk);
        `CHK("pins", 8'hFF, out_pins)
        `CHK("irq", 1'b0, irq)
        rd("pin_cfg", 8'h34, 32'h0, 1'b0);
        rd("status_a", 8'h04, 32'h0, 1'b0);
        rd("unmapped", 8'hFC, 32'h0, 1'b1);
    endtask : t_reset

    task automatic t_port_bits;
        wr(8'h38, 8'hA5);
        settle();
        `CHK("pins", 8'h5A, out_pins)
        wr(8'h38, 8'h00);
        settle();
        `CHK("pins", 8'h5A, out_pins)
        wr(8'h38, 8'h18);
        settle();
        `CHK("pins", 8'h42, out_pins)
        wr(8'h3C, 8'hFF);
        rd("set_reg", 8'h38, 32'h0, 1'b0);
    endtask : t_port_bits

    task automatic t_pin_func;
        @(posedge pclk);
        ch[1].tx_ready <= 1'b1;
        ct_output <= 1'b1;
        wr(8'h34, 8'hF4);
        rd("pin_cfg", 8'h34, 32'hF4, 1'b0);
        settle();
        `CHK("pins", 8'h77, out_pins)
        push(0, 11'h041);
        settle();
        `CHK("pins", 8'h67, out_pins)
        push(1, 11'h042);
        settle();
        `CHK("pins", 8'h47, out_pins)
        @(posedge pclk);
        ch[0].tx_ready <= 1'b1;
        ch[1].tx_ready <= 1'b0;
        ct_output <= 1'b0;
        settle();
        `CHK("pins", 8'h8F, out_pins)
        wr(8'h34, 8'h00);
        wr(8'h08, 8'h20);
        wr(8'h28, 8'h20);
    endtask : t_pin_func

    task automatic t_char_mode;
        push(0, 11'h411);
        push(0, 11'h022);
        rd("status_a", 8'h04, 32'h85, 1'b0);
        rd("rx_a", 8'h0C, 32'h11, 1'b0);
        rd("status_a", 8'h04, 32'h05, 1'b0);
        rd("rx_a", 8'h0C, 32'h22, 1'b0);
        rd("status_a", 8'h04, 32'h04, 1'b0);
        push(0, 11'h433);
        wr(8'h08, 8'h40);
        rd("status_a", 8'h04, 32'h05, 1'b0);
        rd("rx_a", 8'h0C, 32'h33, 1'b0);
    endtask : t_char_mode

    task automatic t_block_mode;
        wr(8'h40, 8'h01);
        push(0, 11'h255);
        push(0, 11'h066);
        rd("rx_a", 8'h0C, 32'h55, 1'b0);
        rd("rx_a", 8'h0C, 32'h66, 1'b0);
        rd("status_a", 8'h04, 32'h44, 1'b0);
        wr(8'h08, 8'h40);
        rd("status_a", 8'h04, 32'h04, 1'b0);
        push(0, 11'h177);
        rd("rx_a", 8'h0C, 32'h77, 1'b0);
        rd("status_a", 8'h04, 32'h24, 1'b0);
        wr(8'h08, 8'h20);
        rd("status_a", 8'h04, 32'h04, 1'b0);
    endtask : t_block_mode

    task automatic t_overrun_irq;
        @(posedge pclk);
        ch[1].tx_empty <= 1'b1;
        for (int i = 0; i < 9; i++)
            push(1, 11'(i));
        rd("status_b", 8'h24, 32'h1B, 1'b0);
        wr(8'h40, 8'h09);
        wr(8'h34, 8'h20);
        settle();
        `CHK("pins", 8'hDF, out_pins)
        wr(8'h34, 8'h00);
        rd("irq_stat", 8'h44, 32'h0F, 1'b0);
        `CHK("irq", 1'b0, irq)
        wr(8'h48, 8'h08);
        settle();
        `CHK("irq", 1'b1, irq)
        wr(8'h44, 8'h08);
        settle();
        `CHK("irq", 1'b0, irq)
        rd("irq_stat", 8'h44, 32'h07, 1'b0);
    endtask : t_overrun_irq

    // ========================================================================
    // Verdict and main sequence.
    task automatic results;
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    initial
    begin
        presetn = 1'b0;
        ch[0] = '0;
        ch[1] = '0;
        ct_output = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_port_bits();
        t_pin_func();
        t_char_mode();
        t_block_mode();
        t_overrun_irq();
        results();
    end

    initial
    begin
        #500000;
        mismatches++;
        results();
    end
endmodule : tb
